// ==== src/bls_in_filter.sv ====
`timescale 1ns/10ps
module bls_in_filter
  import bls_pkg::*;
#(
  parameter int WIDTH = NUM_IN,
  parameter int DEPTH = FILT_DEPTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw and filtered inputs
  bls_in_if.filter io
);

  typedef struct packed {
    logic [WIDTH-1:0][DEPTH-1:0] hist;
    logic [WIDTH-1:0] level;
  } bls_filt_state_type;

  bls_filt_state_type s;
  bls_filt_state_type next_s;
  logic [WIDTH-1:0] all_high;
  logic [WIDTH-1:0] all_low;

  // Agreement of the whole history per input
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign all_high[g] = &s.hist[g];
      assign all_low[g] = ~|s.hist[g];
    end
  endgenerate

  // Shift samples in; a level changes only after DEPTH equal samples
  always_comb begin
    next_s = s;
    for (int i = 0; i < WIDTH; i++) begin
      next_s.hist[i] = {s.hist[i][DEPTH-2:0], io.raw[i]};
      if (all_high[i]) begin
        next_s.level[i] = 1'b1;
      end else if (all_low[i]) begin
        next_s.level[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign io.filt = s.level;

endmodule

// ==== src/bls_in_if.sv ====
`timescale 1ns/10ps
// Raw field inputs and their filtered levels
interface bls_in_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] filt;
  modport filter (input raw, output filt);
  modport user (output raw, input filt);
endinterface

// ==== src/bls_pkg.sv ====
package bls_pkg;

  // Clock and base time unit
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1000000000;
  localparam int TICK_CYCLES_DEFAULT = SECOND_NS / CLK_PERIOD_NS;

  // Sequence times, in seconds unless named otherwise
  localparam int INIT_S = 10;
  localparam int INIT_MAX_MIN = 4;
  localparam int INIT_MAX_S = INIT_MAX_MIN * 60;
  localparam int AIRFLOW_S = 10;
  localparam int STBY_FLAME_S = 240;
  localparam int PRE_FLAME_S = 30;
  localparam int PILOT_LONG_S = 10;
  localparam int PILOT_SHORT_S = 4;
  localparam int MAIN_TRIAL_S = 10;
  localparam int COMMIT_HOLD_S = 5;
  localparam int SETTLE_S = 1;
  localparam int JUMPER_HOURS = 200;
  localparam int JUMPER_LIMIT_S = JUMPER_HOURS * 3600;

  // Postpurge setting steps, seconds
  localparam int PP_FINE_MAX = 60;
  localparam int PP_MID_MAX = 600;
  localparam int PP_MAX = 3600;
  localparam int PP_FINE_STEP = 1;
  localparam int PP_MID_STEP = 10;
  localparam int PP_COARSE_STEP = 60;

  // Setup password digits
  localparam logic [3:0] PW_DIGIT1 = 4'h7;
  localparam logic [3:0] PW_DIGIT2 = 4'h8;

  // Input filter depth and input bit positions
  localparam int FILT_DEPTH = 4;
  localparam int NUM_IN = 8;
  localparam int IN_CALL = 0;
  localparam int IN_AIR = 1;
  localparam int IN_FLAME = 2;
  localparam int IN_FB_PILOT = 3;
  localparam int IN_FB_MAIN = 4;
  localparam int IN_FB_IGN = 5;
  localparam int IN_BTN = 6;
  localparam int IN_LINE = 7;

  // Jumper bits: 1 = intact, 0 = clipped
  localparam int JR_TRIAL = 0;
  localparam int JR_FLAME = 1;
  localparam int JR_AIR = 2;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PASSWORD = 8'h04;
  localparam logic [7:0] REG_POSTPURGE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_INPUTS = 8'h10;

  // Fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_CARD = 8'h01;
  localparam logic [7:0] FAULT_SELF = 8'h02;
  localparam logic [7:0] FAULT_LINE = 8'h03;
  localparam logic [7:0] FAULT_AIR = 8'h04;
  localparam logic [7:0] FAULT_FLAME_ON = 8'h05;
  localparam logic [7:0] FAULT_FEEDBACK = 8'h06;
  localparam logic [7:0] FAULT_NO_FLAME = 8'h07;
  localparam logic [7:0] FAULT_JUMPER = 8'h6e;

  // Sequence phases
  typedef enum logic [2:0] {
    PH_INIT = 3'b000,
    PH_STANDBY = 3'b001,
    PH_PREPURGE = 3'b010,
    PH_PILOT = 3'b011,
    PH_MAIN = 3'b100,
    PH_RUN = 3'b101,
    PH_POSTPURGE = 3'b110,
    PH_LOCKOUT = 3'b111
  } bls_phase_type;

endpackage

// ==== src/bls_supervisor.sv ====
`timescale 1ns/10ps
module bls_supervisor
  import bls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Field inputs
  input wire logic call_for_heat,
  input wire logic airflow_switch,
  input wire logic flame_signal,
  input wire logic pilot_feedback,
  input wire logic main_feedback,
  input wire logic ignition_feedback,
  input wire logic reset_button,
  input wire logic line_ok,
  input wire logic [2:0] jumpers,
  input wire logic card_present,
  input wire logic card_bad,
  input wire logic [11:0] card_purge_s,
  input wire logic self_fault,
  // Retained settings read at power-up
  input wire logic nv_lockout_in,
  input wire logic [7:0] nv_fault_in,
  input wire logic [11:0] nv_postpurge_in,
  input wire logic [2:0] nv_jumpers_in,
  input wire logic [19:0] nv_run_s_in,
  // Retained settings to store
  output logic nv_lockout,
  output logic [7:0] nv_fault,
  output logic [11:0] nv_postpurge,
  output logic [2:0] nv_jumpers,
  output logic [19:0] nv_run_s,
  // Field outputs
  output logic blower,
  output logic pilot_valve,
  output logic ignition,
  output logic main_valve,
  output logic alarm
);

  typedef struct packed {
    logic [31:0] tick;
    bls_phase_type phase;
    logic [11:0] phase_s;
    logic [7:0] init_s;
    logic [7:0] flame_s;
    logic [11:0] pp_left;
    logic [19:0] run_s;
    logic [2:0] jsnap;
    logic loaded;
    logic locked;
    logic [7:0] fault;
    logic air_seen;
    logic btn_q;
    logic [1:0] pw;
    logic setup_open;
    logic confirmed;
    logic [11:0] pending;
    logic [11:0] postpurge;
    logic [2:0] hold_s;
    logic a_sel;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic blower;
    logic pilot;
    logic ign;
    logic main;
    logic alarm;
  } bls_state_type;

  bls_state_type s;
  bls_state_type next_s;
  bls_in_if #(.WIDTH(NUM_IN)) in_bus();
  logic [NUM_IN-1:0] f;

  // Raw inputs into the filter
  assign in_bus.raw[IN_CALL] = call_for_heat;
  assign in_bus.raw[IN_AIR] = airflow_switch;
  assign in_bus.raw[IN_FLAME] = flame_signal;
  assign in_bus.raw[IN_FB_PILOT] = pilot_feedback;
  assign in_bus.raw[IN_FB_MAIN] = main_feedback;
  assign in_bus.raw[IN_FB_IGN] = ignition_feedback;
  assign in_bus.raw[IN_BTN] = reset_button;
  assign in_bus.raw[IN_LINE] = line_ok;
  assign f = in_bus.filt;

  bls_in_filter #(.WIDTH(NUM_IN), .DEPTH(FILT_DEPTH)) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .io(in_bus)
  );

  // Next postpurge step up
  function automatic logic [11:0] pp_up(input logic [11:0] v);
    if (v < 12'(PP_FINE_MAX)) begin
      pp_up = v + 12'(PP_FINE_STEP);
    end else if (v < 12'(PP_MID_MAX)) begin
      pp_up = v + 12'(PP_MID_STEP);
    end else if (v < 12'(PP_MAX)) begin
      pp_up = v + 12'(PP_COARSE_STEP);
    end else begin
      pp_up = 12'(PP_MAX);
    end
  endfunction

  // Next postpurge step down
  function automatic logic [11:0] pp_down(input logic [11:0] v);
    if (v == 12'h000) begin
      pp_down = 12'h000;
    end else if (v <= 12'(PP_FINE_MAX)) begin
      pp_down = v - 12'(PP_FINE_STEP);
    end else if (v <= 12'(PP_MID_MAX)) begin
      pp_down = v - 12'(PP_MID_STEP);
    end else begin
      pp_down = v - 12'(PP_COARSE_STEP);
    end
  endfunction

  // Sequencer, safety checks, setup and bus in one next-state function
  always_comb begin
    logic sec;
    logic lock;
    logic recycle;
    logic settled;
    logic trip_air;
    logic [7:0] code;
    logic [11:0] air_deadline;
    logic [11:0] trial_len;
    logic [31:0] rd;
    next_s = s;
    sec = (s.tick == 32'(TICK_CYCLES - 1));
    lock = 1'b0;
    recycle = 1'b0;
    code = FAULT_NONE;
    settled = (s.phase_s >= 12'(SETTLE_S));
    trip_air = !jumpers[JR_AIR] && !f[IN_AIR];
    air_deadline = (card_purge_s < 12'(AIRFLOW_S)) ? card_purge_s : 12'(AIRFLOW_S);
    trial_len = jumpers[JR_TRIAL] ? 12'(PILOT_LONG_S) : 12'(PILOT_SHORT_S);
    rd = 32'h00000000;
    next_s.tick = sec ? 32'h00000000 : s.tick + 32'h00000001;
    next_s.btn_q = f[IN_BTN];

    // Seconds in phase and continuous flame seconds
    if (sec) begin
      if (s.phase_s != 12'hfff) begin
        next_s.phase_s = s.phase_s + 12'h001;
      end
      if (f[IN_FLAME] && s.flame_s != 8'hff) begin
        next_s.flame_s = s.flame_s + 8'h01;
      end
    end
    if (!f[IN_FLAME]) begin
      next_s.flame_s = 8'h00;
    end

    // Jumpers may change freely until the operating-hours limit
    if (s.run_s < 20'(JUMPER_LIMIT_S)) begin
      next_s.jsnap = jumpers;
    end

    // Faults common to every active phase
    if (s.loaded && s.phase != PH_LOCKOUT) begin
      if (!card_present || card_bad) begin
        lock = 1'b1;
        code = FAULT_CARD;
      end else if (self_fault) begin
        lock = 1'b1;
        code = FAULT_SELF;
      end
    end

    case (s.phase)
      PH_INIT: begin
        if (!s.loaded) begin
          // First cycle after power-up: restore retained state
          next_s.loaded = 1'b1;
          next_s.postpurge = nv_postpurge_in;
          next_s.pending = nv_postpurge_in;
          next_s.jsnap = nv_jumpers_in;
          next_s.run_s = nv_run_s_in;
          next_s.phase_s = 12'h000;
          if (nv_lockout_in) begin
            next_s.phase = PH_LOCKOUT;
            next_s.locked = 1'b1;
            next_s.fault = nv_fault_in;
          end
        end else begin
          if (s.run_s >= 20'(JUMPER_LIMIT_S) && jumpers != s.jsnap && !lock) begin
            lock = 1'b1;
            code = FAULT_JUMPER;
          end
          if (sec && s.init_s != 8'hff) begin
            next_s.init_s = s.init_s + 8'h01;
          end
          if (s.init_s >= 8'(INIT_MAX_S) && !lock) begin
            lock = 1'b1;
            code = FAULT_LINE;
          end
          if (!f[IN_LINE]) begin
            next_s.phase_s = 12'h000;
          end else if (s.phase_s >= 12'(INIT_S)) begin
            next_s.phase = PH_STANDBY;
          end
        end
      end
      PH_STANDBY: begin
        if (s.flame_s >= 8'(STBY_FLAME_S) && !lock) begin
          lock = 1'b1;
          code = FAULT_FLAME_ON;
        end
        if (settled && (f[IN_FB_PILOT] || f[IN_FB_IGN] || f[IN_FB_MAIN]) && !lock) begin
          lock = 1'b1;
          code = FAULT_FEEDBACK;
        end
        if (f[IN_CALL] && !lock) begin
          next_s.phase = PH_PREPURGE;
        end
      end
      PH_PREPURGE: begin
        if (f[IN_AIR]) begin
          next_s.air_seen = 1'b1;
        end
        if ((s.air_seen && !f[IN_AIR]) || (!s.air_seen && s.phase_s >= air_deadline)) begin
          if (!jumpers[JR_AIR]) begin
            lock = 1'b1;
            code = FAULT_AIR;
          end else begin
            recycle = 1'b1;
          end
        end
        if (s.flame_s >= 8'(PRE_FLAME_S) && !lock) begin
          lock = 1'b1;
          code = FAULT_FLAME_ON;
        end
        if (settled && (f[IN_FB_PILOT] || f[IN_FB_IGN] || f[IN_FB_MAIN]) && !lock) begin
          lock = 1'b1;
          code = FAULT_FEEDBACK;
        end
        if (!f[IN_CALL]) begin
          next_s.phase = PH_STANDBY;
        end else if (s.phase_s >= card_purge_s && s.air_seen && f[IN_AIR]) begin
          next_s.phase = PH_PILOT;
        end
      end
      PH_PILOT: begin
        if (trip_air && !lock) begin
          lock = 1'b1;
          code = FAULT_AIR;
        end
        if (settled && (!f[IN_FB_PILOT] || f[IN_FB_MAIN]) && !lock) begin
          lock = 1'b1;
          code = FAULT_FEEDBACK;
        end
        if (s.phase_s >= trial_len) begin
          if (f[IN_FLAME]) begin
            next_s.phase = PH_MAIN;
          end else if (!lock) begin
            lock = 1'b1;
            code = FAULT_NO_FLAME;
          end
        end
      end
      PH_MAIN: begin
        if (trip_air && !lock) begin
          lock = 1'b1;
          code = FAULT_AIR;
        end
        if (!f[IN_FLAME] && !lock) begin
          lock = 1'b1;
          code = FAULT_NO_FLAME;
        end
        if (settled && (f[IN_FB_IGN] || !f[IN_FB_PILOT] || !f[IN_FB_MAIN]) && !lock) begin
          lock = 1'b1;
          code = FAULT_FEEDBACK;
        end
        if (s.phase_s >= 12'(MAIN_TRIAL_S)) begin
          next_s.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        if (sec && s.run_s != 20'hfffff) begin
          next_s.run_s = s.run_s + 20'h00001;
        end
        if (trip_air && !lock) begin
          lock = 1'b1;
          code = FAULT_AIR;
        end
        if (settled && (!f[IN_FB_MAIN] || f[IN_FB_IGN]) && !lock) begin
          lock = 1'b1;
          code = FAULT_FEEDBACK;
        end
        if (!f[IN_FLAME] && !jumpers[JR_FLAME] && !lock) begin
          lock = 1'b1;
          code = FAULT_NO_FLAME;
        end
        if (!f[IN_CALL] || !f[IN_FLAME]) begin
          // Demand ended or flame recycle: fan runs on for postpurge
          next_s.phase = (s.postpurge == 12'h000) ? PH_STANDBY : PH_POSTPURGE;
          // Extra count covers the part second before the first tick
          next_s.pp_left = s.postpurge + 12'h001;
        end
      end
      PH_POSTPURGE: begin
        if (sec) begin
          next_s.pp_left = s.pp_left - 12'h001;
          if (s.pp_left == 12'h001) begin
            next_s.phase = PH_STANDBY;
          end
        end
      end
      default: begin
        // Lockout: blower runs out any postpurge; a reset press at any time ends it and restarts
        if (sec && s.pp_left != 12'h000) begin
          next_s.pp_left = s.pp_left - 12'h001;
        end
        if (f[IN_BTN] && !s.btn_q) begin
          next_s.phase = PH_INIT;
          next_s.locked = 1'b0;
          next_s.fault = FAULT_NONE;
          next_s.pp_left = 12'h000;
        end
      end
    endcase

    // Safety shutdown: latch lockout with the phase-dependent blower action
    if (lock) begin
      next_s.phase = PH_LOCKOUT;
      next_s.locked = 1'b1;
      next_s.fault = code;
      if (s.phase == PH_PILOT || s.phase == PH_MAIN || s.phase == PH_RUN) begin
        // Extra count so the fan runs at least the full postpurge time
        next_s.pp_left = (s.postpurge == 12'h000) ? 12'h000 : s.postpurge + 12'h001;
      end else begin
        next_s.pp_left = 12'h000;
      end
    end

    // Fresh counters on phase change or purge recycle
    if (next_s.phase != s.phase || recycle) begin
      next_s.phase_s = 12'h000;
      next_s.air_seen = 1'b0;
      if (next_s.phase != PH_INIT) begin
        next_s.init_s = 8'h00;
      end
    end

    // Commit of confirmed setup by holding the reset button
    if (s.phase == PH_STANDBY && s.confirmed && f[IN_BTN]) begin
      if (sec) begin
        next_s.hold_s = s.hold_s + 3'h1;
      end
      // Wait for one more tick so a whole hold time has surely passed
      if (s.hold_s > 3'(COMMIT_HOLD_S)) begin
        next_s.postpurge = s.pending;
        next_s.confirmed = 1'b0;
        next_s.setup_open = 1'b0;
        next_s.hold_s = 3'h0;
      end
    end else begin
      next_s.hold_s = 3'h0;
    end

    // Setup closes whenever standby is left
    if (next_s.phase != PH_STANDBY) begin
      next_s.pw = 2'h0;
      next_s.setup_open = 1'b0;
      next_s.confirmed = 1'b0;
      next_s.pending = next_s.postpurge;
    end

    // Bus data phase: write effects
    if (s.a_sel && s.a_wr) begin
      if (s.a_addr == REG_CTRL) begin
        if (hwdata[0] && s.phase == PH_LOCKOUT) begin
          next_s.phase = PH_INIT;
          next_s.locked = 1'b0;
          next_s.fault = FAULT_NONE;
          next_s.pp_left = 12'h000;
          next_s.phase_s = 12'h000;
        end
      end else if (s.a_addr == REG_PASSWORD) begin
        if (s.phase == PH_STANDBY) begin
          if (s.pw == 2'h0 && hwdata[3:0] == PW_DIGIT1) begin
            next_s.pw = 2'h1;
          end else if (s.pw == 2'h1 && hwdata[3:0] == PW_DIGIT2) begin
            next_s.pw = 2'h0;
            next_s.setup_open = 1'b1;
          end else begin
            next_s.pw = 2'h0;
          end
        end
      end else if (s.a_addr == REG_POSTPURGE) begin
        if (s.setup_open && s.phase == PH_STANDBY) begin
          if (hwdata[0]) begin
            next_s.pending = pp_up(s.pending);
          end else if (hwdata[1]) begin
            next_s.pending = pp_down(s.pending);
          end
          if (hwdata[2]) begin
            next_s.confirmed = 1'b1;
          end
        end
      end
    end

    // Bus address phase: capture and prepare read data
    next_s.a_sel = hsel && hready && htrans[1];
    next_s.a_wr = hwrite;
    next_s.a_addr = haddr[7:0];
    if (haddr[7:0] == REG_POSTPURGE) begin
      rd = {4'h0, s.postpurge, 4'h0, s.pending};
    end else if (haddr[7:0] == REG_STATUS) begin
      rd = {16'h0000, s.fault, 2'h0, s.confirmed, s.setup_open, s.locked, s.phase};
    end else if (haddr[7:0] == REG_INPUTS) begin
      rd = {20'h00000, 1'b0, jumpers, f};
    end
    next_s.rdata = (next_s.a_sel && !hwrite) ? rd : 32'h00000000;

    // Field outputs follow the next phase
    next_s.blower = (next_s.phase inside {PH_PREPURGE, PH_PILOT, PH_MAIN, PH_RUN,
                     PH_POSTPURGE}) || (next_s.phase == PH_LOCKOUT && next_s.pp_left != 12'h000);
    next_s.pilot = (next_s.phase == PH_PILOT) || (next_s.phase == PH_MAIN);
    next_s.ign = (next_s.phase == PH_PILOT);
    next_s.main = (next_s.phase == PH_MAIN) || (next_s.phase == PH_RUN);
    next_s.alarm = (next_s.phase == PH_LOCKOUT);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Bus answers: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;

  // Retained settings and field outputs
  assign nv_lockout = s.locked;
  assign nv_fault = s.fault;
  assign nv_postpurge = s.postpurge;
  assign nv_jumpers = s.jsnap;
  assign nv_run_s = s.run_s;
  assign blower = s.blower;
  assign pilot_valve = s.pilot;
  assign ignition = s.ign;
  assign main_valve = s.main;
  assign alarm = s.alarm;

endmodule

// ==== testbench/bls_asserts.sv ====
`timescale 1ns/10ps
module bls_asserts
  import bls_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  // Clock, reset and bus activity
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  // Field side
  input wire logic reset_button,
  input wire logic card_present,
  input wire logic self_fault,
  input wire logic blower,
  input wire logic pilot_valve,
  input wire logic ignition,
  input wire logic main_valve,
  input wire logic alarm,
  input wire logic nv_lockout,
  input wire logic [11:0] nv_postpurge
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles with neither a button press nor a bus access
  logic [3:0] quiet;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet <= 4'h0;
    else if (reset_button || hsel) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  property p_fuel; alarm |-> !pilot_valve && !main_valve && !ignition; endproperty
  a_fuel: assert property (p_fuel) else $error("fuel on in lockout");
  property p_card; !card_present |-> ##[1:4] alarm; endproperty
  a_card: assert property (p_card) else $error("no lockout on card loss");
  property p_self; self_fault |-> ##[1:4] alarm; endproperty
  a_self: assert property (p_self) else $error("no lockout on self fault");
  property p_ign; main_valve |-> !ignition; endproperty
  a_ign: assert property (p_ign) else $error("ignition with main valve");
  property p_pp0; $rose(alarm) && nv_postpurge == 12'h0 |-> !blower; endproperty
  a_pp0: assert property (p_pp0) else $error("blower left on");
  property p_nostart; alarm && $past(alarm) |-> !$rose(blower); endproperty
  a_nostart: assert property (p_nostart) else $error("start in lockout");
  property p_nv; $rose(alarm) |-> ##[0:1] nv_lockout; endproperty
  a_nv: assert property (p_nv) else $error("lockout not retained");
  property p_hold; alarm && quiet == 4'hf |=> alarm; endproperty
  a_hold: assert property (p_hold) else $error("lockout cleared");
endmodule
bind bls_supervisor bls_asserts #(.TICK_CYCLES(TICK_CYCLES)) bls_asserts_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .reset_button(reset_button),
  .card_present(card_present), .self_fault(self_fault), .blower(blower),
  .pilot_valve(pilot_valve), .ignition(ignition), .main_valve(main_valve),
  .alarm(alarm), .nv_lockout(nv_lockout), .nv_postpurge(nv_postpurge));

// ==== testbench/bls_field_model.sv ====
`timescale 1ns/10ps
module bls_field_model (
  // Clock and bench controls
  input wire logic hclk,
  input wire logic flame_ok,
  input wire logic air_ok,
  // Relay drives
  input wire logic blower,
  input wire logic pilot_valve,
  input wire logic main_valve,
  input wire logic ignition,
  // Sensed levels
  output logic airflow_switch,
  output logic flame_signal,
  output logic pilot_feedback,
  output logic main_feedback,
  output logic ignition_feedback
);
  // Contacts follow relays a cycle late; flame needs fuel
  always_ff @(posedge hclk) begin
    pilot_feedback <= pilot_valve;
    main_feedback <= main_valve;
    ignition_feedback <= ignition;
    airflow_switch <= blower && air_ok;
    flame_signal <= (pilot_valve || main_valve) && flame_ok;
  end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import bls_pkg::*;
;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, call_for_heat = '0;
  logic reset_button = '0, line_ok = 1'h1, card_present = 1'h1, self_fault = '0, card_bad = '0;
  logic flame_ok = 1'h1, air_ok = 1'h1, nv_lockout_in = '0;
  logic [1:0] htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic hreadyout, hresp, blower, pilot_valve, ignition, main_valve, alarm, nv_lockout;
  logic airflow_switch, flame_signal, pilot_feedback, main_feedback, ignition_feedback;
  logic [2:0] jumpers = 3'h7, nv_jumpers_in = 3'h7, nv_jumpers;
  logic [7:0] nv_fault_in = '0, nv_fault;
  logic [11:0] nv_postpurge_in = '0, nv_postpurge;
  logic [19:0] nv_run_s_in = '0, nv_run_s;
  int miscompares = 0, checks_done = 0, cyc = 0;
  // Register rows: address, mask, expected
  logic [71:0] rows [4] = '{{REG_STATUS, 32'hff3f, 32'h1}, {REG_INPUTS, 32'h7ff, 32'h780},
    {REG_POSTPURGE, 32'hfff0fff, 32'h0}, {8'h14, 32'hffffffff, 32'h0}};
  bls_supervisor #(.TICK_CYCLES(20)) bls_supervisor_i (.hsize(3'h2), .hready(hreadyout),
    .card_purge_s(12'h003), .*);
  bls_field_model bls_field_model_i (.*);
  // Clock and hang guard
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One single-word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic wait_ph(input logic [2:0] ph, input string what);
    int n;
    n = 0;
    do begin
      bus(1'h0, REG_STATUS, '0);
      n++;
    end while (q[2:0] !== ph && n < 400);
    check(q & 32'h7, {29'h0, ph}, what);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    wait_ph(PH_STANDBY, "initiate");
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, rows[i][71:64], '0);
      check((q & rows[i][63:32]) | {hresp, 31'h0}, rows[i][31:0], "register row");
    end
    $display("test power-up done");
    for (int k = 0; k < 3; k++) begin
      if (k == 0) card_present <= 1'h0;
      else if (k == 1) self_fault <= 1'h1;
      else card_bad <= 1'h1;
      repeat (4) @(posedge hclk);
      card_present <= 1'h1;
      self_fault <= 1'h0;
      card_bad <= 1'h0;
      repeat (20) bus(1'h0, REG_STATUS, '0);
      check({q[15:8], alarm, blower}, {k[0] ? FAULT_SELF : FAULT_CARD, 2'h2}, "lock");
      bus(1'h1, REG_CTRL, 32'h1);
      wait_ph(PH_STANDBY, "remote reset");
    end
    $display("test standby faults done");
    bus(1'h1, REG_POSTPURGE, 32'h1);
    bus(1'h1, REG_PASSWORD, 32'h7);
    bus(1'h1, REG_PASSWORD, 32'h8);
    repeat (3) bus(1'h1, REG_POSTPURGE, 32'h1);
    bus(1'h1, REG_POSTPURGE, 32'h2);
    bus(1'h1, REG_POSTPURGE, 32'h4);
    bus(1'h0, REG_STATUS, '0);
    check(q & 32'h30, 32'h30, "setup open");
    bus(1'h0, REG_POSTPURGE, '0);
    check(q & 32'hfff, 32'h2, "pending");
    reset_button <= 1'h1;
    repeat (100) @(posedge hclk);
    check({20'h0, nv_postpurge}, 32'h0, "early commit");
    repeat (40) @(posedge hclk);
    reset_button <= 1'h0;
    check({20'h0, nv_postpurge}, 32'h2, "commit");
    $display("test setup done");
    call_for_heat <= 1'h1;
    wait_ph(PH_RUN, "reach run");
    check({blower, ignition, main_valve, pilot_valve}, 4'ha, "run outputs");
    call_for_heat <= 1'h0;
    repeat (16) @(posedge hclk);
    check({blower, main_valve}, 2'h2, "postpurge fan");
    repeat (29) @(posedge hclk);
    check(blower, 1'h1, "postpurge length");
    repeat (31) @(posedge hclk);
    check(blower, 1'h0, "postpurge end");
    wait_ph(PH_STANDBY, "cycle end");
    $display("test normal cycle done");
    flame_ok <= 1'h0;
    call_for_heat <= 1'h1;
    wait_ph(PH_LOCKOUT, "no flame");
    check({q[15:8], alarm, blower, main_valve}, {FAULT_NO_FLAME, 3'h6}, "trial stop");
    call_for_heat <= 1'h0;
    flame_ok <= 1'h1;
    repeat (38) @(posedge hclk);
    check(blower, 1'h1, "trial postpurge length");
    repeat (22) @(posedge hclk);
    check(blower, 1'h0, "trial postpurge end");
    nv_lockout_in <= nv_lockout;
    nv_fault_in <= nv_fault;
    nv_postpurge_in <= nv_postpurge;
    nv_jumpers_in <= nv_jumpers;
    nv_run_s_in <= nv_run_s;
    hresetn <= 1'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    wait_ph(PH_LOCKOUT, "lock kept");
    check(q[15:8], FAULT_NO_FLAME, "fault kept");
    bus(1'h0, REG_POSTPURGE, '0);
    check(q & 32'hfff0000, 32'h20000, "postpurge kept");
    reset_button <= 1'h1;
    repeat (8) @(posedge hclk);
    reset_button <= 1'h0;
    wait_ph(PH_STANDBY, "local reset");
    $display("test trial fault done");
    tally_and_finish();
  end
endmodule
